// ### dv/sacs_tb.sv
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: APB master tasks, divider 0 gives converter clock of pclk/2
// Notes:   Lengths measured in pclk cycles from bus or trigger edge to done pulse
`timescale 1ns/1ps
`include "sacs_map.svh"
module testbench;
  import sacs_pkg::*;

  logic            pclk;
  logic            presetn;
  sacs_apb_req_t   req;
  sacs_apb_rsp_t   rsp;
  logic            trigger_in;
  logic [9:0]      sar_result;
  sacs_afe_t       afe;
  int              n_fail;
  int              checks_done;
  int              n_done;
  time             t_acc;
  time             t0;
  time             last_done;
  time             prev_done;
  time             last_sh;
  time             t_trig;
  logic [31:0]     r;
  logic            e;
  int              base;

  sacs_top sacs_top_inst (
    .pclk       (pclk),
    .presetn    (presetn),
    .apb_req    (req),
    .apb_rsp    (rsp),
    .trigger_in (trigger_in),
    .sar_result (sar_result),
    .afe        (afe)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Done and sample strobes observed mid-cycle
  always @(negedge pclk) begin
    if (afe.conv_done === 1'b1) begin
      n_done++;
      prev_done = last_done;
      last_done = $time;
    end
    if (afe.sample_hold === 1'b1) last_sh = $time;
  end

  task automatic final_report();
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi);
    checks_done++;
    if (v < lo || v > hi) begin
      $display("[ERR] t=%0t got %h exp %h..%h", $time, v, lo, hi);
      n_fail++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd_o,
                     output logic err_o);
    int n;
    n = 0;
    @(posedge pclk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    chk({31'h0, rsp.pready}, 32'h1);
    rd_o  = rsp.prdata;
    err_o = rsp.pslverr;
    t_acc = $time;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    logic        de;
    apb(1'b1, a, d, dummy, de);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] rd_o);
    logic de;
    apb(1'b0, a, 32'h0, rd_o, de);
  endtask

  task automatic wait_done(input int target);
    int n;
    n = 0;
    while (n_done < target && n < 600) begin
      @(negedge pclk);
      n++;
    end
    chk(n_done, target);
  endtask

  task automatic trig();
    @(posedge pclk);
    trigger_in <= 1'b1;
    t0 = $time;
    repeat (6) @(posedge pclk);
    trigger_in <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask

  task automatic run_free(input logic [31:0] cw, input int gap);
    wr(`SACS_OFF_CTRL, 32'h0);
    wr(`SACS_OFF_CTRL, {cw[31:4], 4'h1});
    wr(`SACS_OFF_CTRL, cw);
    base = n_done;
    wait_done(base + 3);
    chk((last_done - prev_done) / 4, gap);
    rd(`SACS_OFF_CTRL, r);
    chk(r[1], 1'b1);
  endtask

  initial begin
    #100000;
    n_fail++;
    final_report();
  end

  initial begin
    presetn = 1'b0;
    req = '0;
    trigger_in = 1'b0;
    sar_result = 10'h2a5;
    n_fail = 0;
    checks_done = 0;
    n_done = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(`SACS_OFF_CTRL, r);
    chk(r, 32'h0);
    rd(`SACS_OFF_SELECT, r);
    chk(r, 32'h0);
    rd(`SACS_OFF_STATUS, r);
    chk(r, 32'h0);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    wr(`SACS_OFF_CTRL, 32'h2);
    rd(`SACS_OFF_CTRL, r);
    chk(r, 32'h0);
    // First conversion after enable
    wr(`SACS_OFF_SELECT, 32'h35);
    wr(`SACS_OFF_CTRL, 32'h1);
    wr(`SACS_OFF_CTRL, 32'h3);
    t0 = t_acc;
    rd(`SACS_OFF_CTRL, r);
    chk(r[1], 1'b1);
    rd(`SACS_OFF_STATUS, r);
    chk({r[3], r[1]}, 2'h3);
    wr(`SACS_OFF_SELECT, 32'h77);
    @(negedge pclk);
    chk(afe.active_sel, 8'h35);
    wait_done(1);
    rng((last_done - t0) / 4, 50, 54);
    chk((last_done - last_sh) / 4, 23);
    chk(afe.active_sel, 8'h77);
    rd(`SACS_OFF_CTRL, r);
    chk(r, 32'h1);
    rd(`SACS_OFF_STATUS, r);
    chk({r[15:8], r[0]}, 9'h0ef);
    rd(`SACS_OFF_RES_LOW, r);
    chk(r, 32'ha5);
    rd(`SACS_OFF_RES_HIGH, r);
    chk(r, 32'h2);
    wr(`SACS_OFF_STATUS, 32'h1);
    rd(`SACS_OFF_STATUS, r);
    chk(r[0], 1'b0);
    // Low byte read locks the result
    rd(`SACS_OFF_RES_LOW, r);
    rd(`SACS_OFF_STATUS, r);
    chk(r[4], 1'b1);
    sar_result <= 10'h15a;
    wr(`SACS_OFF_CTRL, 32'h3);
    t0 = t_acc;
    wait_done(2);
    rng((last_done - t0) / 4, 26, 30);
    chk((last_done - last_sh) / 4, 23);
    rd(`SACS_OFF_STATUS, r);
    chk(r[0], 1'b1);
    rd(`SACS_OFF_RES_LOW, r);
    chk(r, 32'ha5);
    rd(`SACS_OFF_RES_HIGH, r);
    chk(r, 32'h2);
    wr(`SACS_OFF_CTRL, 32'h3);
    wait_done(3);
    rd(`SACS_OFF_RES_LOW, r);
    chk(r, 32'h5a);
    rd(`SACS_OFF_RES_HIGH, r);
    chk(r, 32'h1);
    // Disable mid-conversion, then extended again
    wr(`SACS_OFF_CTRL, 32'h3);
    wr(`SACS_OFF_CTRL, 32'h0);
    rd(`SACS_OFF_CTRL, r);
    chk(r, 32'h0);
    chk(afe.sync_clk, 1'b0);
    repeat (60) @(negedge pclk);
    chk(n_done, 3);
    wr(`SACS_OFF_CTRL, 32'h1);
    @(negedge pclk);
    e = afe.sync_clk;
    repeat (2) @(negedge pclk);
    chk(afe.sync_clk, !e);
    wr(`SACS_OFF_CTRL, 32'h3);
    t0 = t_acc;
    wait_done(4);
    rng((last_done - t0) / 4, 50, 54);
    // Triggered conversion, second edge ignored
    wr(`SACS_OFF_CTRL, 32'h5);
    trig();
    t_trig = t0;
    trig();
    wait_done(5);
    rng((last_done - t_trig) / 4, 29, 35);
    repeat (60) @(negedge pclk);
    chk(n_done, 5);
    trig();
    wait_done(6);
    rng((last_done - t0) / 4, 29, 35);
    chk((last_done - last_sh) / 4, 23);
    // Triggered differential
    wr(`SACS_OFF_CTRL, 32'h0);
    wr(`SACS_OFF_CTRL, 32'h15);
    trig();
    wait_done(7);
    rd(`SACS_OFF_STATUS, r);
    chk(r[2], 1'b0);
    trig();
    wait_done(8);
    rd(`SACS_OFF_STATUS, r);
    chk(r[2], 1'b1);
    wr(`SACS_OFF_STATUS, 32'h4);
    rd(`SACS_OFF_STATUS, r);
    chk(r[2], 1'b0);
    // User-started differential, either sync phase
    repeat (2) begin
      wr(`SACS_OFF_CTRL, 32'h13);
      t0 = t_acc;
      base = n_done;
      wait_done(base + 1);
      rng((last_done - t0) / 4, 26, 32);
    end
    // Free running: normal, differential, slower divider
    run_free(32'h0f, 26);
    run_free(32'h1f, 28);
    run_free(32'h4f, 52);
    wr(`SACS_OFF_CTRL, 32'h0);
    final_report();
  end
endmodule // testbench

// ### rtl/sacs_map.svh
// Purpose: Offsets, fields, reset values and timing counts of the sequencer
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Timing counts are in half cycles of the converter clock
`ifndef SACS_MAP_SVH
`define SACS_MAP_SVH

`define SACS_OFF_CTRL      8'h00
`define SACS_OFF_SELECT    8'h04
`define SACS_OFF_STATUS    8'h08
`define SACS_OFF_RES_LOW   8'h0c
`define SACS_OFF_RES_HIGH  8'h10

// Control fields
`define SACS_CTRL_ENABLE   0
`define SACS_CTRL_START    1
`define SACS_CTRL_AUTO     2
`define SACS_CTRL_FREE     3
`define SACS_CTRL_DIFF     4
`define SACS_CTRL_DIV_LO   5
`define SACS_CTRL_DIV_HI   7

// Status fields
`define SACS_STAT_DONE     0
`define SACS_STAT_BUSY     1
`define SACS_STAT_INVALID  2
`define SACS_STAT_FIRST    3
`define SACS_STAT_LOCK     4

`define SACS_CTRL_RESET    3'h0
`define SACS_SELECT_RESET  8'h00

// Half-cycle counts: 13, 25, 13.5 cycles long
`define SACS_NORM_LEN_X2   6'h1a
`define SACS_FIRST_LEN_X2  6'h32
`define SACS_AUTO_LEN_X2   6'h1b
// Sample points: 1.5, 13.5, 2 cycles
`define SACS_NORM_SH_X2    6'h03
`define SACS_FIRST_SH_X2   6'h1b
`define SACS_AUTO_SH_X2    6'h04
// One extra cycle for sync-clock alignment
`define SACS_DIFF_EXTRA_X2 6'h02

`endif

// ### rtl/sacs_pkg.sv
// Purpose: Types shared by the sequencer modules
// Assumes: Constants live in sacs_map.svh
// Notes:   None
package sacs_pkg;

  typedef enum logic [1:0] {
    SACS_IDLE,
    SACS_WAIT_EDGE,
    SACS_CONVERT
  } sacs_phase_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } sacs_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sacs_apb_rsp_t;

  typedef struct packed {
    logic       sample_hold;
    logic       conv_done;
    logic       sync_clk;
    logic [7:0] active_sel;
  } sacs_afe_t;

endpackage

// ### rtl/sacs_prescaler.sv
// Purpose: Converter clock divider giving rise and fall enable pulses
// Assumes: Divide ratio is 2 to the power div_sel, at least 2
// Notes:   Held in reset while run is low; restart realigns the phase
`timescale 1ns/1ps
module sacs_prescaler #(
  parameter int CNT_W = 7
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [2:0] div_sel,
  output logic            tick_rise,
  output logic            tick_fall
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             level;
    logic             rise;
    logic             fall;
  } sacs_presc_t;

  sacs_presc_t s_reg;
  sacs_presc_t s_next;
  logic [7:0]       full;
  logic [CNT_W-1:0] lim;

  always_comb begin
    full = 8'h01 << div_sel;
    lim  = (div_sel == 3'h0) ? CNT_W'(1) : CNT_W'(full[7:1]);
    s_next      = s_reg;
    s_next.rise = 1'b0;
    s_next.fall = 1'b0;
    if (!run) begin
      s_next.cnt   = '0;
      s_next.level = 1'b0;
    end else if (restart) begin
      s_next.cnt   = '0;
      s_next.level = 1'b1;
    end else if (s_reg.cnt == lim - CNT_W'(1)) begin
      s_next.cnt   = '0;
      s_next.level = ~s_reg.level;
      s_next.rise  = ~s_reg.level;
      s_next.fall  = s_reg.level;
    end else begin
      s_next.cnt = s_reg.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick_rise = s_reg.rise;
  assign tick_fall = s_reg.fall;

endmodule // sacs_prescaler

// ### rtl/sacs_top.sv
// Purpose: Conversion sequencer for a successive-approximation converter
// Assumes: APB slave, trigger from a pin, result from the analog side
// Notes:   Converter clock is an enable pulse pair from the prescaler
//
// Overview of operation
// - Normal conversion lasts thirteen converter cycles
// - First conversion after enable lasts 25
// - Sample at 1.5, first at 13.5
// - Completion stores result, sets flag, clears start
// - New start waits for next rising edge
// - Trigger resets the prescaler
// - Triggered: sample at 2, length 13.5
// - Three CPU cycles of trigger synchronisation
// - Free running restarts at once, start stays
// - Differential sample aligned to half-rate clock
// - Differential user start: 13 or 14 cycles
// - Free-running differential restarts take 14 cycles
// - Triggered differential invalid unless freshly enabled
// - Selection buffer frozen during conversion until its last converter cycle
// - Free-run reselection applies one conversion later
// - Start bit reads one while converting
// - Low byte read locks result until high
// - Prescaler held reset while disabled
// - Trigger edges during conversion are ignored
`timescale 1ns/1ps
`include "sacs_map.svh"
module sacs_top (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire sacs_pkg::sacs_apb_req_t apb_req,
  output sacs_pkg::sacs_apb_rsp_t  apb_rsp,
  input  wire logic                trigger_in,
  input  wire logic [9:0]          sar_result,
  output sacs_pkg::sacs_afe_t      afe
);
  import sacs_pkg::*;

  typedef struct packed {
    sacs_phase_t phase;
    logic [5:0]  cnt;
    logic [5:0]  len;
    logic [5:0]  sh;
    logic        enable;
    logic        start;
    logic        auto_en;
    logic        free_run;
    logic        diff;
    logic [2:0]  div_sel;
    logic [7:0]  sel_reg;
    logic [7:0]  active_sel;
    logic        first;
    logic        done_flag;
    logic        invalid_flag;
    logic        lock;
    logic [9:0]  result;
    logic        sync_clk;
    logic [2:0]  trig_s;
    logic        trig_stable;
    logic        sample_hold;
    logic        conv_done;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sacs_state_t;

  sacs_state_t s_reg;
  sacs_state_t s_next;
  logic        tick_rise;
  logic        tick_fall;
  logic        restart;
  logic        trig_edge;
  logic        setup;
  logic        access;
  logic [5:0]  cnt_inc;

  sacs_prescaler #(
    .CNT_W (7)
  ) u_presc (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (s_reg.enable),
    .restart   (restart),
    .div_sel   (s_reg.div_sel),
    .tick_rise (tick_rise),
    .tick_fall (tick_fall)
  );

  always_comb begin
    s_next             = s_reg;
    s_next.sample_hold = 1'b0;
    s_next.conv_done   = 1'b0;
    s_next.pready      = 1'b0;
    s_next.pslverr     = 1'b0;
    setup   = apb_req.psel && !apb_req.penable;
    access  = apb_req.psel && apb_req.penable && s_reg.pready;
    cnt_inc = s_reg.cnt + 6'h01;

    s_next.trig_s = {s_reg.trig_s[1:0], trigger_in};
    if (s_reg.trig_s[1] == s_reg.trig_s[2]) begin
      s_next.trig_stable = s_reg.trig_s[2];
    end
    trig_edge = (s_reg.trig_s[1] == s_reg.trig_s[2]) && s_reg.trig_s[2] &&
                !s_reg.trig_stable;
    restart = trig_edge && s_reg.auto_en && s_reg.enable &&
              (s_reg.phase == SACS_IDLE);

    // Register read data and error
    if (setup) begin
      s_next.pready = 1'b1;
      s_next.prdata = 32'h0;
      if (apb_req.paddr == `SACS_OFF_CTRL) begin
        s_next.prdata[`SACS_CTRL_ENABLE] = s_reg.enable;
        s_next.prdata[`SACS_CTRL_START]  = s_reg.start;
        s_next.prdata[`SACS_CTRL_AUTO]   = s_reg.auto_en;
        s_next.prdata[`SACS_CTRL_FREE]   = s_reg.free_run;
        s_next.prdata[`SACS_CTRL_DIFF]   = s_reg.diff;
        s_next.prdata[`SACS_CTRL_DIV_HI:`SACS_CTRL_DIV_LO] = s_reg.div_sel;
      end else if (apb_req.paddr == `SACS_OFF_SELECT) begin
        s_next.prdata[7:0] = s_reg.sel_reg;
      end else if (apb_req.paddr == `SACS_OFF_STATUS) begin
        s_next.prdata[`SACS_STAT_DONE]    = s_reg.done_flag;
        s_next.prdata[`SACS_STAT_BUSY]    = s_reg.phase != SACS_IDLE;
        s_next.prdata[`SACS_STAT_INVALID] = s_reg.invalid_flag;
        s_next.prdata[`SACS_STAT_FIRST]   = s_reg.first;
        s_next.prdata[`SACS_STAT_LOCK]    = s_reg.lock;
        s_next.prdata[15:8]               = s_reg.active_sel;
      end else if (apb_req.paddr == `SACS_OFF_RES_LOW) begin
        s_next.prdata[7:0] = s_reg.result[7:0];
      end else if (apb_req.paddr == `SACS_OFF_RES_HIGH) begin
        s_next.prdata[1:0] = s_reg.result[9:8];
      end else begin
        s_next.pslverr = 1'b1;
      end
    end

    // Register writes and read side effects
    if (access && apb_req.pwrite) begin
      if (apb_req.paddr == `SACS_OFF_CTRL) begin
        s_next.enable   = apb_req.pwdata[`SACS_CTRL_ENABLE];
        s_next.auto_en  = apb_req.pwdata[`SACS_CTRL_AUTO];
        s_next.free_run = apb_req.pwdata[`SACS_CTRL_FREE];
        s_next.diff     = apb_req.pwdata[`SACS_CTRL_DIFF];
        s_next.div_sel  =
          apb_req.pwdata[`SACS_CTRL_DIV_HI:`SACS_CTRL_DIV_LO];
        if (!s_reg.enable && apb_req.pwdata[`SACS_CTRL_ENABLE]) begin
          s_next.first = 1'b1;
        end
        if (apb_req.pwdata[`SACS_CTRL_START] &&
            apb_req.pwdata[`SACS_CTRL_ENABLE] && s_reg.enable &&
            (s_reg.phase == SACS_IDLE) && !restart) begin
          s_next.start = 1'b1;
          s_next.phase = SACS_WAIT_EDGE;
        end
      end else if (apb_req.paddr == `SACS_OFF_SELECT) begin
        s_next.sel_reg = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == `SACS_OFF_STATUS) begin
        if (apb_req.pwdata[`SACS_STAT_DONE]) begin
          s_next.done_flag = 1'b0;
        end
        if (apb_req.pwdata[`SACS_STAT_INVALID]) begin
          s_next.invalid_flag = 1'b0;
        end
      end
    end
    if (access && !apb_req.pwrite) begin
      if (apb_req.paddr == `SACS_OFF_RES_LOW) begin
        s_next.lock = 1'b1;
      end else if (apb_req.paddr == `SACS_OFF_RES_HIGH) begin
        s_next.lock = 1'b0;
      end
    end

    if (tick_rise) begin
      s_next.sync_clk = ~s_reg.sync_clk;
    end

    case (s_reg.phase)
      SACS_IDLE: begin
        s_next.active_sel = s_reg.sel_reg;
        if (restart) begin
          s_next.phase      = SACS_CONVERT;
          s_next.cnt        = 6'h00;
          s_next.start      = 1'b1;
          s_next.active_sel = s_reg.sel_reg;
          if (s_reg.first) begin
            s_next.len = `SACS_FIRST_LEN_X2;
            s_next.sh  = `SACS_FIRST_SH_X2;
          end else begin
            s_next.len = `SACS_AUTO_LEN_X2;
            s_next.sh  = `SACS_AUTO_SH_X2;
          end
          if (s_reg.diff && !s_reg.first) begin
            s_next.invalid_flag = 1'b1;
          end
        end
      end
      SACS_WAIT_EDGE: begin
        s_next.active_sel = s_reg.sel_reg;
        if (tick_rise) begin
          s_next.phase = SACS_CONVERT;
          s_next.cnt   = 6'h00;
          s_next.len = s_reg.first ? `SACS_FIRST_LEN_X2 : `SACS_NORM_LEN_X2;
          s_next.sh  = s_reg.first ? `SACS_FIRST_SH_X2 : `SACS_NORM_SH_X2;
          if (s_reg.diff && s_reg.sync_clk) begin
            s_next.len = s_next.len + `SACS_DIFF_EXTRA_X2;
            s_next.sh  = s_next.sh + `SACS_DIFF_EXTRA_X2;
          end
        end
      end
      SACS_CONVERT: begin
        // Stray tick after disable must not count
        if ((tick_rise || tick_fall) && s_reg.enable) begin
          s_next.cnt = cnt_inc;
          if (cnt_inc == s_reg.sh) begin
            s_next.sample_hold = 1'b1;
          end
          if (cnt_inc >= s_reg.len - 6'h02) begin
            s_next.active_sel = s_reg.sel_reg;
          end
          if (cnt_inc == s_reg.len) begin
            s_next.conv_done = 1'b1;
            s_next.done_flag = 1'b1;
            s_next.first     = 1'b0;
            if (!s_reg.lock) begin
              s_next.result = sar_result;
            end
            if (s_reg.auto_en && s_reg.free_run) begin
              s_next.cnt = 6'h00;
              s_next.len = `SACS_NORM_LEN_X2;
              s_next.sh  = `SACS_NORM_SH_X2;
              if (s_reg.diff) begin
                s_next.len = `SACS_NORM_LEN_X2 + `SACS_DIFF_EXTRA_X2;
                s_next.sh  = `SACS_NORM_SH_X2 + `SACS_DIFF_EXTRA_X2;
              end
            end else begin
              s_next.start = 1'b0;
              s_next.phase = SACS_IDLE;
            end
          end
        end
      end
      default: begin
        s_next.phase = SACS_IDLE;
      end
    endcase

    if (!s_reg.enable) begin
      s_next.phase    = SACS_IDLE;
      s_next.start    = 1'b0;
      s_next.cnt      = 6'h00;
      s_next.sync_clk = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg         <= '0;
      s_reg.div_sel <= `SACS_CTRL_RESET;
      s_reg.sel_reg <= `SACS_SELECT_RESET;
      s_reg.phase   <= SACS_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign apb_rsp.pready     = s_reg.pready;
  assign apb_rsp.pslverr    = s_reg.pslverr;
  assign apb_rsp.prdata     = s_reg.prdata;
  assign afe.sample_hold    = s_reg.sample_hold;
  assign afe.conv_done      = s_reg.conv_done;
  assign afe.sync_clk       = s_reg.sync_clk;
  assign afe.active_sel     = s_reg.active_sel;

  default clocking sacs_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  norm_len_a: assert property (
    (s_reg.phase == SACS_WAIT_EDGE && tick_rise && s_reg.enable &&
     !s_reg.first && !s_reg.diff) |=> (s_reg.len == 6'h1a))
    else $error("normal conversion length wrong");

  first_len_a: assert property (
    (s_reg.phase == SACS_WAIT_EDGE && tick_rise && s_reg.enable &&
     s_reg.first && !s_reg.diff) |=> (s_reg.len == 6'h32 && s_reg.sh == 6'h1b))
    else $error("first conversion timing wrong");

  sample_point_a: assert property (
    s_reg.sample_hold |-> (s_reg.cnt == s_reg.sh && s_reg.phase != SACS_IDLE))
    else $error("sample strobe off its point");

  done_clear_a: assert property (
    (s_reg.conv_done && !$past(s_reg.free_run)) |->
      (s_reg.done_flag && !s_reg.start))
    else $error("completion did not set flag or clear start");

  trig_time_a: assert property (
    (restart && !s_reg.first) |=>
      (s_reg.phase == SACS_CONVERT && s_reg.len == 6'h1b && s_reg.sh == 6'h04))
    else $error("triggered timing wrong");

  diff_extra_a: assert property (
    (s_reg.phase == SACS_WAIT_EDGE && tick_rise && s_reg.enable &&
     s_reg.diff && s_reg.sync_clk && !s_reg.first) |=> (s_reg.len == 6'h1c))
    else $error("differential extra cycle missing");

  diff_low_a: assert property (
    (s_reg.phase == SACS_WAIT_EDGE && tick_rise && s_reg.enable &&
     s_reg.diff && !s_reg.sync_clk && !s_reg.first) |=> (s_reg.len == 6'h1a))
    else $error("differential low-phase length wrong");

  busy_start_a: assert property (
    (s_reg.phase != SACS_IDLE) |-> s_reg.start)
    else $error("start bit low while busy");

  result_lock_a: assert property (
    ($past(s_reg.lock) && s_reg.conv_done) |->
      (s_reg.result == $past(s_reg.result)))
    else $error("locked result was overwritten");

  presc_off_a: assert property (
    (!s_reg.enable ##1 !s_reg.enable) |-> (!tick_rise && !tick_fall))
    else $error("prescaler ticking while disabled");

  trig_ignore_a: assert property (
    (s_reg.phase == SACS_CONVERT && trig_edge && s_reg.enable &&
     !(s_reg.auto_en && s_reg.free_run) && s_reg.cnt != 6'h00) |=>
      (s_reg.cnt != 6'h00))
    else $error("trigger taken during conversion");

endmodule // sacs_top
